// File: tb_top.sv
// self-checking bench for the timer flag block
// assumes the core model beside it and the bound checker
`timescale 1ns/1ps
module tb_top;
  import tif_pkg::*;
  logic clock = 0, rst = 1, wr = 0, rd = 0, legacy_mode = 0, glb = 0, timer_tick = 0, slow = 0;
  tif_addr_t addr = '0;
  tif_byte_t wdata = '0, rdata;
  logic [9:0] ev = '0;
  logic [5:0] m = '0;
  logic [1:0] top = '0;
  logic [3:0] u1_irq_en = 4'hf;
  tif_vec_t   irq_req, irq_ack;
  int fails = 0, checks = 0;
  // vector entries counted per request line; sticky, so a short ack is never missed
  int acks [10] = '{default: 0};
  // addr, flag byte, request index, source: below 8 an event bit, else 8 + match channel
  localparam logic [19:0] CASES [12] = '{20'h12000, 20'h12001, 20'h10432, 20'h32043,
    20'h32044, 20'h30475, 20'h11018, 20'h10829, 20'h3019a, 20'h3105b, 20'h3086c, 20'h3028d};
  always #5 clock = ~clock;
  tif_irq i_dut (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata, .legacy_mode,
    .global_irq_en(glb), .timer_tick, .u1_capture_event(ev[0]), .u1_capture_is_top(top[0]),
    .u1_at_top(ev[1]), .u1_match_a(m[0]), .u1_match_b(m[1]), .u1_match_c(m[2]),
    .u1_overflow(ev[2]), .u1_force_cmp_a(ev[6]), .u1_force_cmp_b(ev[7]),
    .u3_capture_event(ev[3]), .u3_capture_is_top(top[1]), .u3_at_top(ev[4]),
    .u3_match_a(m[3]), .u3_match_b(m[4]), .u3_match_c(m[5]), .u3_overflow(ev[5]),
    .u3_force_cmp_a(ev[8]), .u3_force_cmp_b(ev[9]), .u1_irq_en, .irq_req, .irq_ack);
  tif_core_model i_core (.clock, .rst, .slow, .irq_req, .irq_ack);
  always @(posedge clock) begin
    for (int k = 0; k < 10; k++) begin
      if (irq_ack[k] === 1'b1) acks[k]++;
    end
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input tif_addr_t a, input tif_byte_t d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input tif_addr_t a, input tif_byte_t e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask : rd_chk
  task automatic fire(input logic [19:0] c);
    @(posedge clock);
    if (c[3]) begin
      m[c[2:0]]  <= 1'b1;
      timer_tick <= 1'b1;
    end else begin
      ev[c[2:0]] <= 1'b1;
      top        <= {c[2:0] == 3'h4, c[2:0] == 3'h1};
    end
    @(posedge clock);
    ev         <= '0;
    m          <= '0;
    top        <= '0;
    timer_tick <= 1'b0;
    // match seen on one tick, flag only on the next one
    if (c[3]) begin
      rd_chk(c[19:16], 8'h00);
      @(posedge clock);
      timer_tick <= 1'b1;
      @(posedge clock);
      timer_tick <= 1'b0;
    end
  endtask : fire
  task automatic run_case(input logic [19:0] c, input int i);
    int n;
    int a0;
    fire(c);
    rd_chk(c[19:16], c[15:8]);
    wr_reg(c[19:16], 8'h00);
    rd_chk(c[19:16], c[15:8]);
    check(irq_req[c[7:4]], 1'b0);
    wr_reg(c[19:16], c[15:8]);
    rd_chk(c[19:16], 8'h00);
    @(posedge clock);
    glb  <= 1'b1;
    slow <= ~i[0];
    a0 = acks[c[7:4]];
    fire(c);
    wr_reg(c[19:16], 8'h00);
    // look off the edge, after the counter has settled
    for (n = 0; n < 20 && acks[c[7:4]] == a0; n++) begin
      @(posedge clock);
      #1;
    end
    check(n < 20, 1'b1);
    if (n == 20) tally_and_finish();
    glb <= 1'b0;
    rd_chk(c[19:16], 8'h00);
  endtask : run_case
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd_chk(a[3:0], a == 0 ? 8'h3c : 8'h00);
    wr_reg(4'h7, 8'hff);
    rd_chk(4'h7, 8'h00);
    @(posedge clock);
    legacy_mode <= 1'b1;
    wr_reg(4'h2, 8'h3f);
    rd_chk(4'h2, 8'h00);
    @(posedge clock);
    legacy_mode <= 1'b0;
    wr_reg(4'h2, 8'hff);
    rd_chk(4'h2, 8'h3f);
    @(posedge clock);
    ev[9:6]    <= 4'hf;
    timer_tick <= 1'b1;
    @(posedge clock);
    ev <= '0;
    @(posedge clock);
    timer_tick <= 1'b0;
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h3, 8'h00);
    for (int i = 0; i < 12; i++) run_case(CASES[i], i);
    tally_and_finish();
  end
endmodule : tb_top

// File: tif_core_model.sv
// core-side model: takes the lowest pending request as a vector entry
// assumes one request handled at a time; slow adds three cycles of latency
`timescale 1ns/1ps
module tif_core_model (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // latency select
  input  wire logic             slow,
  // request handshake
  input  wire tif_pkg::tif_vec_t irq_req,
  output      tif_pkg::tif_vec_t irq_ack
);
  import tif_pkg::*;
  logic [1:0] wait_cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_ack  <= '0;
      wait_cnt <= '0;
    end else begin
      irq_ack <= '0;
      // ack gap of one cycle, so a cleared flag is never taken twice
      if (irq_req != '0 && irq_ack == '0) begin
        if (slow && wait_cnt != 2'h3) begin
          wait_cnt <= wait_cnt + 2'h1;
        end else begin
          wait_cnt <= '0;
          irq_ack  <= irq_req & (~irq_req + 10'h1);
        end
      end
    end
  end
endmodule : tif_core_model

// File: tif_defs.svh
// constants for the timer interrupt flag and enable block
// assumes an 8-bit register port with one-cycle read latency
// Function
// [R1] u3 capture request when its enable, global enable and flag are all set.
// [R2] u3 compare-A request when its enable, global enable and flag are set.
// [R3] u3 compare-B request when its enable, global enable and flag are set.
// [R4] u3 overflow request when its enable, global enable and flag are set.
// [R5] u3 compare-C request when its enable, global enable and flag are set.
// [R6] u1 compare-C request when its enable, global enable and flag are set.
// [R7] bits 7:6 of extended enable and flags read zero; software writes zero.
// [R8] extended enable register absent in legacy compatibility mode.
// [R9] u1 capture flag set on a u1 capture pin event.
// [R10] u1 capture flag set at top when capture register is top.
// [R11] u1 capture flag clears on vector execution or written one.
// [R12] u1 compare A/B flags set one timer clock after counter match.
// [R13] u1 force strobes A/B never set compare flags.
// [R14] u1 compare A/B flags clear on vector execution or written one.
// [R15] u1 overflow flag set on overflow in normal and clear-on-compare modes.
// [R16] u1 overflow flag clears on vector execution or written one.
// [R17] u3 capture flag set on a u3 capture pin event.
// [R18] u3 capture flag set at top when capture register is top.
// [R19] u3 capture flag clears on vector execution or written one.
// [R20] u3 compare A/B flags set one timer clock after counter match.
// [R21] u3 force strobes A/B never set compare flags.
// [R22] u3 compare A/B flags clear on vector execution or written one.
// [R23] u3 overflow flag set on overflow; clears on vector or written one.
// [R24] compare-C flags set after match, not by force; clear on vector or one.
// [R25] writing zero to a flag bit leaves that flag unchanged.
`ifndef TIF_DEFS_SVH
`define TIF_DEFS_SVH
`define TIF_ADDR_ENABLE     4'h0
`define TIF_ADDR_FLAGS      4'h1
`define TIF_ADDR_EXT_ENABLE 4'h2
`define TIF_ADDR_EXT_FLAGS  4'h3
`define TIF_RESET_BYTE      8'h00
`define TIF_BIT_CAPTURE     5
`define TIF_BIT_CMPA        4
`define TIF_BIT_CMPB        3
`define TIF_BIT_OVERFLOW    2
`define TIF_BIT_U3_CMPC     1
`define TIF_BIT_U1_CMPC     0
`define TIF_EXT_USED_MASK   8'h3f
`define TIF_MAIN_USED_MASK  8'h3c
`endif

// File: tif_irq.sv
// flags and enables for counter units 1 and 3 with request outputs
// assumes event strobes come from clock-domain logic, one cycle each
`timescale 1ns/1ps
`include "tif_defs.svh"
module tif_irq (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // register port
  input  wire tif_pkg::tif_addr_t addr,
  input  wire tif_pkg::tif_byte_t wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output      tif_pkg::tif_byte_t rdata,
  // mode straps and core state
  input  wire logic           legacy_mode,
  input  wire logic           global_irq_en,
  // timer clock enable, one pulse per timer tick
  input  wire logic           timer_tick,
  // unit 1 events
  input  wire logic           u1_capture_event,
  input  wire logic           u1_capture_is_top,
  input  wire logic           u1_at_top,
  input  wire logic           u1_match_a,
  input  wire logic           u1_match_b,
  input  wire logic           u1_match_c,
  input  wire logic           u1_overflow,
  input  wire logic           u1_force_cmp_a,
  input  wire logic           u1_force_cmp_b,
  // unit 3 events
  input  wire logic           u3_capture_event,
  input  wire logic           u3_capture_is_top,
  input  wire logic           u3_at_top,
  input  wire logic           u3_match_a,
  input  wire logic           u3_match_b,
  input  wire logic           u3_match_c,
  input  wire logic           u3_overflow,
  input  wire logic           u3_force_cmp_a,
  input  wire logic           u3_force_cmp_b,
  // main enable bits for unit 1 held elsewhere
  input  wire logic [3:0]     u1_irq_en,
  // core interrupt handshake
  output      tif_pkg::tif_vec_t irq_req,
  input  wire tif_pkg::tif_vec_t irq_ack
);
  import tif_pkg::*;

  // request index: 0 u1 cap, 1 u1 a, 2 u1 b, 3 u1 ovf, 4 u3 cap,
  // 5 u3 a, 6 u3 b, 7 u3 ovf, 8 u3 c, 9 u1 c
  tif_byte_t flags;
  tif_byte_t ext_flags;
  tif_byte_t ext_enable;
  tif_byte_t next_flags;
  tif_byte_t next_ext_flags;
  tif_byte_t flag_set;
  tif_byte_t ext_flag_set;
  tif_byte_t flag_clr;
  tif_byte_t ext_flag_clr;
  logic      u1_match_a_d;
  logic      u1_match_b_d;
  logic      u1_match_c_d;
  logic      u3_match_a_d;
  logic      u3_match_b_d;
  logic      u3_match_c_d;

  function automatic logic hit(input tif_addr_t a, input tif_addr_t ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  // match seen on one tick, flag set on the next; force strobes never
  // feed this path, so they cannot set a flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      u1_match_a_d <= 1'b0;
      u1_match_b_d <= 1'b0;
      u1_match_c_d <= 1'b0;
      u3_match_a_d <= 1'b0;
      u3_match_b_d <= 1'b0;
      u3_match_c_d <= 1'b0;
    end else if (timer_tick) begin
      u1_match_a_d <= u1_match_a; // [R12] [R13]
      u1_match_b_d <= u1_match_b; // [R12] [R13]
      u1_match_c_d <= u1_match_c; // [R24]
      u3_match_a_d <= u3_match_a; // [R20] [R21]
      u3_match_b_d <= u3_match_b; // [R20] [R21]
      u3_match_c_d <= u3_match_c; // [R24]
    end
  end

  always_comb begin
    flag_set = 8'h00;
    // capture pin is disconnected when capture register is top
    flag_set[`TIF_BIT_CAPTURE] = u1_capture_is_top ? u1_at_top     // [R10]
                                                    : u1_capture_event; // [R9]
    flag_set[`TIF_BIT_CMPA]     = timer_tick & u1_match_a_d;        // [R12]
    flag_set[`TIF_BIT_CMPB]     = timer_tick & u1_match_b_d;        // [R12]
    // overflow strobe is produced per the selected waveform mode upstream
    flag_set[`TIF_BIT_OVERFLOW] = u1_overflow;                      // [R15]
    ext_flag_set = 8'h00;
    ext_flag_set[`TIF_BIT_CAPTURE] = u3_capture_is_top ? u3_at_top  // [R18]
                                                        : u3_capture_event; // [R17]
    ext_flag_set[`TIF_BIT_CMPA]     = timer_tick & u3_match_a_d;    // [R20]
    ext_flag_set[`TIF_BIT_CMPB]     = timer_tick & u3_match_b_d;    // [R20]
    ext_flag_set[`TIF_BIT_OVERFLOW] = u3_overflow;                  // [R23]
    ext_flag_set[`TIF_BIT_U3_CMPC]  = timer_tick & u3_match_c_d;    // [R24]
    ext_flag_set[`TIF_BIT_U1_CMPC]  = timer_tick & u1_match_c_d;    // [R24]
  end

  always_comb begin
    flag_clr = {2'b00, irq_ack[0], irq_ack[1], irq_ack[2], irq_ack[3], 2'b00};
    ext_flag_clr = {2'b00, irq_ack[4], irq_ack[5], irq_ack[6], irq_ack[7],
                    irq_ack[8], irq_ack[9]};
    // write-one clears, zeros leave the flag alone
    if (wr && hit(addr, `TIF_ADDR_FLAGS)) begin
      flag_clr = flag_clr | (wdata & `TIF_MAIN_USED_MASK); // [R11] [R14] [R16] [R25]
    end
    if (wr && hit(addr, `TIF_ADDR_EXT_FLAGS)) begin
      ext_flag_clr = ext_flag_clr | (wdata & `TIF_EXT_USED_MASK); // [R19] [R22] [R24]
    end
    // set wins over a clear in the same cycle
    next_flags     = ((flags & ~flag_clr) | flag_set) & `TIF_MAIN_USED_MASK;
    next_ext_flags = ((ext_flags & ~ext_flag_clr) | ext_flag_set) & `TIF_EXT_USED_MASK; // [R7]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags     <= `TIF_RESET_BYTE;
      ext_flags <= `TIF_RESET_BYTE;
    end else begin
      flags     <= next_flags;
      ext_flags <= next_ext_flags;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_enable <= `TIF_RESET_BYTE;
    end else if (legacy_mode) begin
      ext_enable <= `TIF_RESET_BYTE; // [R8]
    end else if (wr && hit(addr, `TIF_ADDR_EXT_ENABLE)) begin
      ext_enable <= wdata & `TIF_EXT_USED_MASK; // [R7]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= `TIF_RESET_BYTE;
    end else if (rd) begin
      if (hit(addr, `TIF_ADDR_ENABLE)) begin
        rdata <= {2'b00, u1_irq_en, 2'b00};
      end else if (hit(addr, `TIF_ADDR_FLAGS)) begin
        rdata <= flags;
      end else if (hit(addr, `TIF_ADDR_EXT_ENABLE) && !legacy_mode) begin
        rdata <= ext_enable; // [R8]
      end else if (hit(addr, `TIF_ADDR_EXT_FLAGS)) begin
        rdata <= ext_flags;
      end else begin
        rdata <= `TIF_RESET_BYTE;
      end
    end else begin
      rdata <= `TIF_RESET_BYTE;
    end
  end

  always_comb begin
    irq_req[0] = global_irq_en & u1_irq_en[3] & flags[`TIF_BIT_CAPTURE];
    irq_req[1] = global_irq_en & u1_irq_en[2] & flags[`TIF_BIT_CMPA];
    irq_req[2] = global_irq_en & u1_irq_en[1] & flags[`TIF_BIT_CMPB];
    irq_req[3] = global_irq_en & u1_irq_en[0] & flags[`TIF_BIT_OVERFLOW];
    irq_req[4] = global_irq_en & ext_enable[`TIF_BIT_CAPTURE]
                 & ext_flags[`TIF_BIT_CAPTURE]; // [R1]
    irq_req[5] = global_irq_en & ext_enable[`TIF_BIT_CMPA]
                 & ext_flags[`TIF_BIT_CMPA]; // [R2]
    irq_req[6] = global_irq_en & ext_enable[`TIF_BIT_CMPB]
                 & ext_flags[`TIF_BIT_CMPB]; // [R3]
    irq_req[7] = global_irq_en & ext_enable[`TIF_BIT_OVERFLOW]
                 & ext_flags[`TIF_BIT_OVERFLOW]; // [R4]
    irq_req[8] = global_irq_en & ext_enable[`TIF_BIT_U3_CMPC]
                 & ext_flags[`TIF_BIT_U3_CMPC]; // [R5]
    irq_req[9] = global_irq_en & ext_enable[`TIF_BIT_U1_CMPC]
                 & ext_flags[`TIF_BIT_U1_CMPC]; // [R6]
  end

endmodule : tif_irq

// File: tif_irq_props.sv
// port assertions for the timer flag block
// assumes a bind onto tif_irq and a single clock domain
`timescale 1ns/1ps
module tif_irq_props (
  // clock, reset and register port
  input wire logic              clock, rst, wr, rd,
  input wire tif_pkg::tif_addr_t addr,
  input wire tif_pkg::tif_byte_t wdata, rdata,
  // events and core side
  input wire logic              legacy_mode, global_irq_en, timer_tick, u1_overflow,
  input wire logic              u1_capture_event, u1_capture_is_top, u1_at_top,
  input wire logic              u3_capture_event, u3_capture_is_top, u3_at_top,
  input wire logic [3:0]        u1_irq_en,
  input wire tif_pkg::tif_vec_t irq_req, irq_ack
);
  import tif_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire u1_set = u1_capture_event && !u1_capture_is_top || u1_capture_is_top && u1_at_top;
  wire u3_set = u3_capture_event && !u3_capture_is_top || u3_capture_is_top && u3_at_top;
  resv_zero_a: assert property (rdata[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  global_gate_a: assert property (!global_irq_en |-> irq_req == 10'h0)
    else $error("request without global enable");
  u1cap_set_a: assert property (u1_set ##1 (global_irq_en && u1_irq_en[3]) |-> irq_req[0])
    else $error("capture event gave no request");
  u1ovf_set_a: assert property (u1_overflow ##1 (global_irq_en && u1_irq_en[0]) |-> irq_req[3])
    else $error("overflow gave no request");
  cmpa_src_a: assert property ($rose(irq_req[1]) |-> $past(timer_tick) || !$past(u1_irq_en[2]) || !$past(global_irq_en))
    else $error("compare request without a tick");
  u3cap_ack_a: assert property (irq_ack[4] && !u3_set |=> !irq_req[4])
    else $error("vector entry left capture flag");
  u1cap_w1c_a: assert property (wr && addr == 4'h1 && wdata[5] && !u1_set |=> !irq_req[0])
    else $error("write one left capture flag");
  wzero_keep_a: assert property (wr && addr == 4'h1 && !wdata[5] && !irq_ack[0] && irq_req[0] ##1 (global_irq_en && u1_irq_en[3]) |-> irq_req[0])
    else $error("write zero cleared capture flag");
  legacy_hide_a: assert property (rd && addr == 4'h2 && legacy_mode |=> rdata == 8'h00)
    else $error("extended enable visible in legacy mode");
  cover property (irq_ack[4]);
  cover property (u1_set ##1 irq_req[0]);
  cover property (rd && legacy_mode);
endmodule : tif_irq_props
bind tif_irq tif_irq_props i_props (.clock, .rst, .wr, .rd, .addr, .wdata, .rdata, .legacy_mode,
  .global_irq_en, .timer_tick, .u1_overflow, .u1_capture_event, .u1_capture_is_top, .u1_at_top,
  .u3_capture_event, .u3_capture_is_top, .u3_at_top, .u1_irq_en, .irq_req, .irq_ack);

// File: tif_pkg.sv
// types for the timer interrupt flag and enable block
// assumes the constants header beside it
package tif_pkg;
  typedef logic [7:0] tif_byte_t;
  typedef logic [3:0] tif_addr_t;
  // one bit per request line, index is the request number
  typedef logic [9:0] tif_vec_t;
endpackage : tif_pkg
